/* File: cfg_loader.sv */
// Purpose: Configuration download, staged update and sequencing state fetch.
// Assumes: Serial bus bit level is handled outside; this block sees bytes.
// Notes: Nonvolatile contents live in nvm_mem, which has no reset.
// Function
// - Clip DAC code to lower and upper limits.
// - Inverted limits three-state that DAC buffer.
// - DAC limits restored in startup download.
// - Each setting held in two-stage latch pair.
// - Drivers weakly pulled low until download ends.
// - Download starts after supply leaves lockout.
// - Fill first stage, then transfer all together.
// - Load first state 0.5 ms after download.
// - Not-acknowledge all accesses before download ends.
// - Control bit 0 set makes writes immediate.
// - Control bit 0 clear writes first stage only.
// - Commit bit copies first stage to second.
// - Nonvolatile writes staged by same control bits.
// - Page erase only when erase enable set.
// - Host command reloads configuration from nonvolatile store.
// - Sequencing store holds 63 states of 64 bits.
// - Fetch next state on exit, about 10 us.
// - No volatile copy of sequencing states.
// - First written byte sets the address pointer.
// - Reload register bit 0 copies pages 0-6.
// - Configuration pages 0-6 at store start.
`timescale 1ns/1ps
module cfg_loader #(
  parameter int SE_START_CYCLES = cfg_loader_pkg::SE_START_CYCLES,
  parameter int DAC_COUNT = cfg_loader_pkg::DAC_COUNT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic supply_above_lockout,
  input wire logic host_xfer_start,
  input wire logic host_wr_valid,
  input wire logic [7:0] host_wr_byte,
  input wire logic host_rd_req,
  output logic [7:0] host_rd_byte,
  output logic host_ack,
  input wire logic se_exit_met,
  output logic [63:0] se_state_word,
  output logic [5:0] se_state_index,
  output logic se_state_valid,
  output logic se_loading,
  output logic [8*DAC_COUNT-1:0] dac_drive_code,
  output logic [DAC_COUNT-1:0] dac_buffer_en,
  output logic driver_weak_pull_en,
  output logic config_ready
);
  localparam int CFG_BYTES = cfg_loader_pkg::CFG_BYTES;
  localparam int SE_LOAD_CYCLES = cfg_loader_pkg::SE_LOAD_CYCLES;

  cfg_loader_pkg::load_state_t state_q;
  logic [7:0] nvm_mem [cfg_loader_pkg::NVM_BYTES];
  logic [7:0] latch_a [CFG_BYTES];
  logic [7:0] latch_b [CFG_BYTES];
  logic sync1_q, sync2_q, first_q, commit_q, reload_q, pend_q, cfg_valid_q;
  logic se_busy_q, se_valid_q;
  logic [7:0] copy_idx_q, ptr_q, upd_q, pend_data_q, rd_q;
  logic [15:0] wait_cnt_q, nvm_addr_q;
  logic [9:0] pend_addr_q, se_cnt_q;
  logic [5:0] se_idx_q;
  logic [63:0] se_word_q;
  function automatic logic [9:0] nvm_index(input logic [15:0] addr);
    nvm_index = addr[9:0] - cfg_loader_pkg::NVM_BASE_ADDR[9:0];
  endfunction : nvm_index

  // Supply lockout comparator is asynchronous to the clock.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= supply_above_lockout;
      sync2_q <= sync1_q;
    end
  end

  logic ready, copy_active, copy_last, xfer_all, wait_done, wr_en, ptr_wr, cfg_wr;
  logic ctrl_wr, reload_wr, nvm_hi_wr, nvm_lo_wr, nvm_data_wr, erase_go, nvm_go;
  logic se_start, se_next, se_done;
  logic [9:0] nvm_wr_addr, host_nvm_idx, copy_nvm_idx, se_base;
  logic [7:0] nvm_wr_data, rd_mux;
  logic [63:0] se_word_w;
  logic [5:0] se_next_idx;
  assign ready = state_q == cfg_loader_pkg::ST_READY;
  assign host_ack = ready;
  assign copy_active = state_q == cfg_loader_pkg::ST_COPY;
  assign copy_last = copy_idx_q == 8'(CFG_BYTES - 1);
  assign xfer_all = state_q == cfg_loader_pkg::ST_XFER;
  assign wait_done = wait_cnt_q == 16'(SE_START_CYCLES - 1);
  assign wr_en = host_wr_valid && ready;
  assign ptr_wr = wr_en && first_q;
  assign cfg_wr = wr_en && !first_q && (ptr_q < 8'(CFG_BYTES))
    && (ptr_q != cfg_loader_pkg::REG_USER_RELOAD) && (ptr_q != cfg_loader_pkg::REG_UPDATE_CTRL);
  assign ctrl_wr = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_UPDATE_CTRL);
  assign reload_wr = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_USER_RELOAD);
  assign nvm_hi_wr = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_NVM_ADDR_HI);
  assign nvm_lo_wr = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_NVM_ADDR_LO);
  assign nvm_data_wr = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_NVM_DATA);
  assign erase_go = wr_en && !first_q && (ptr_q == cfg_loader_pkg::REG_NVM_ERASE)
    && upd_q[cfg_loader_pkg::UPD_ERASE_EN];
  assign host_nvm_idx = nvm_index(nvm_addr_q);
  assign copy_nvm_idx = {2'b00, copy_idx_q};
  assign nvm_go = (nvm_data_wr && upd_q[cfg_loader_pkg::UPD_TRANSPARENT])
    || (commit_q && pend_q);
  assign nvm_wr_addr = commit_q ? pend_addr_q : host_nvm_idx;
  assign nvm_wr_data = commit_q ? pend_data_q : host_wr_byte;
  assign se_base = cfg_loader_pkg::SE_NVM_BASE + {1'b0, se_idx_q, 3'b000};
  assign se_start = (state_q == cfg_loader_pkg::ST_WAIT_SE) && wait_done;
  assign se_next = se_exit_met && se_valid_q && !se_busy_q;
  assign se_done = se_busy_q && (se_cnt_q == 10'(SE_LOAD_CYCLES - 1));
  assign se_next_idx = (se_idx_q == 6'(cfg_loader_pkg::SE_STATES - 1)) ? 6'h00
    : se_idx_q + 6'h01;

  genvar k;
  generate
    for (k = 0; k < cfg_loader_pkg::SE_WORD_BYTES; k++)
    begin : g_se_word
      assign se_word_w[8*k +: 8] = nvm_mem[se_base + 10'(k)];
    end
  endgenerate

  assign rd_mux = (ptr_q == cfg_loader_pkg::REG_UPDATE_CTRL) ? upd_q
    : (ptr_q == cfg_loader_pkg::REG_USER_RELOAD) ? cfg_loader_pkg::ZERO_BYTE
    : (ptr_q == cfg_loader_pkg::REG_NVM_ADDR_HI) ? nvm_addr_q[15:8]
    : (ptr_q == cfg_loader_pkg::REG_NVM_ADDR_LO) ? nvm_addr_q[7:0]
    : (ptr_q == cfg_loader_pkg::REG_NVM_DATA) ? nvm_mem[host_nvm_idx]
    : (ptr_q < 8'(CFG_BYTES)) ? latch_a[ptr_q] : cfg_loader_pkg::ZERO_BYTE;

  // Load sequencing: lockout, page copy, simultaneous transfer, state fetch delay.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= cfg_loader_pkg::ST_LOCKOUT;
      copy_idx_q <= 8'h00;
      wait_cnt_q <= 16'h0000;
      cfg_valid_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        cfg_loader_pkg::ST_LOCKOUT:
        begin
          if (sync2_q)
            state_q <= cfg_loader_pkg::ST_COPY;
        end
        cfg_loader_pkg::ST_COPY:
        begin
          copy_idx_q <= copy_last ? 8'h00 : copy_idx_q + 8'h01;
          if (copy_last)
          begin
            state_q <= cfg_loader_pkg::ST_XFER;
          end
        end
        cfg_loader_pkg::ST_XFER:
        begin
          cfg_valid_q <= 1'b1;
          state_q <= reload_q ? cfg_loader_pkg::ST_READY : cfg_loader_pkg::ST_WAIT_SE;
        end
        cfg_loader_pkg::ST_WAIT_SE:
        begin
          wait_cnt_q <= wait_cnt_q + 16'h0001;
          if (wait_done)
          begin
            state_q <= cfg_loader_pkg::ST_READY;
          end
        end
        cfg_loader_pkg::ST_READY:
        begin
          if (reload_wr && host_wr_byte[cfg_loader_pkg::RELOAD_GO])
          begin
            state_q <= cfg_loader_pkg::ST_COPY;
          end
        end
      endcase
    end
  end

  // Host side: pointer, control bits, staged nonvolatile write.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      first_q <= 1'b1;
      ptr_q <= 8'h00;
      upd_q <= cfg_loader_pkg::UPD_RESET;
      commit_q <= 1'b0;
      reload_q <= 1'b0;
      nvm_addr_q <= cfg_loader_pkg::NVM_BASE_ADDR;
      pend_q <= 1'b0;
      pend_addr_q <= 10'h000;
      pend_data_q <= 8'h00;
      rd_q <= 8'h00;
    end
    else
    begin
      if (host_xfer_start)
      begin
        first_q <= 1'b1;
      end
      else if (wr_en)
      begin
        first_q <= 1'b0;
      end
      if (ptr_wr)
        ptr_q <= host_wr_byte;
      if (ctrl_wr)
        upd_q <= host_wr_byte & ~(8'h01 << cfg_loader_pkg::UPD_COMMIT);
      commit_q <= ctrl_wr && host_wr_byte[cfg_loader_pkg::UPD_COMMIT];
      if (reload_wr && host_wr_byte[cfg_loader_pkg::RELOAD_GO])
        reload_q <= 1'b1;
      if (nvm_hi_wr)
        nvm_addr_q[15:8] <= host_wr_byte;
      if (nvm_lo_wr)
        nvm_addr_q[7:0] <= host_wr_byte;
      if (nvm_data_wr && !upd_q[cfg_loader_pkg::UPD_TRANSPARENT])
      begin
        pend_q <= 1'b1;
        pend_addr_q <= host_nvm_idx;
        pend_data_q <= host_wr_byte;
      end
      else if (commit_q)
      begin
        pend_q <= 1'b0;
      end
      if (host_rd_req && ready)
        rd_q <= rd_mux;
    end
  end

  // Configuration latch pairs; no reset, filled by the download.
  always_ff @(posedge clock)
  begin
    if (copy_active)
    begin
      latch_a[copy_idx_q] <= nvm_mem[copy_nvm_idx];
    end
    else if (cfg_wr)
    begin
      latch_a[ptr_q] <= host_wr_byte;
    end
    if (xfer_all || commit_q)
    begin
      latch_b <= latch_a;
    end
    else if (cfg_wr && upd_q[cfg_loader_pkg::UPD_TRANSPARENT])
    begin
      latch_b[ptr_q] <= host_wr_byte;
    end
  end

  // Nonvolatile store; a plain clocked process so its contents can be preloaded.
  always @(posedge clock)
  begin
    if (erase_go)
    begin
      for (int i = 0; i < cfg_loader_pkg::PAGE_BYTES; i++)
      begin
        nvm_mem[{host_nvm_idx[9:5], 5'(i)}] <= cfg_loader_pkg::ERASED_BYTE;
      end
    end
    else if (nvm_go)
    begin
      nvm_mem[nvm_wr_addr] <= nvm_wr_data;
    end
  end

  // Sequencing state fetch straight from the nonvolatile store.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      se_idx_q <= 6'h00;
      se_cnt_q <= 10'h000;
      se_busy_q <= 1'b0;
      se_word_q <= 64'h0000000000000000;
      se_valid_q <= 1'b0;
    end
    else
    begin
      if (se_start || se_next)
      begin
        se_busy_q <= 1'b1;
        se_valid_q <= 1'b0;
        se_cnt_q <= 10'h000;
        se_idx_q <= se_start ? 6'h00 : se_next_idx;
      end
      else if (se_done)
      begin
        se_busy_q <= 1'b0;
        se_valid_q <= 1'b1;
        se_word_q <= se_word_w;
      end
      else if (se_busy_q)
      begin
        se_cnt_q <= se_cnt_q + 10'h001;
      end
    end
  end

  generate
    for (k = 0; k < DAC_COUNT; k++)
    begin : g_dac
      dac_limit_clip u_clip (
        .clock(clock),
        .rstn(rstn),
        .cfg_valid(cfg_valid_q),
        .margin_dac_code(latch_b[cfg_loader_pkg::DAC_CODE_BASE + 8'(k)]),
        .dac_lower_limit(latch_b[cfg_loader_pkg::DAC_LOWER_BASE + 8'(k)]),
        .dac_upper_limit(latch_b[cfg_loader_pkg::DAC_UPPER_BASE + 8'(k)]),
        .drive_code(dac_drive_code[8*k +: 8]),
        .buffer_en(dac_buffer_en[k])
      );
    end
  endgenerate

  assign host_rd_byte = rd_q;
  assign se_state_word = se_word_q;
  assign se_state_index = se_idx_q;
  assign se_state_valid = se_valid_q;
  assign se_loading = se_busy_q;
  assign driver_weak_pull_en = !cfg_valid_q;
  assign config_ready = ready;
endmodule : cfg_loader

/* File: cfg_loader_pkg.sv */
// Purpose: Shared constants for the configuration loader and the DAC limit clip.
// Assumes: 50 MHz core clock; byte-wide host port behind the serial bus slave.
// Notes: Addresses are register pointer values unless named as memory indices.
package cfg_loader_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SE_START_DELAY_NS = 500000;
  localparam int SE_START_CYCLES = SE_START_DELAY_NS / CLK_PERIOD_NS;
  localparam int SE_LOAD_NS = 10000;
  localparam int SE_LOAD_CYCLES = SE_LOAD_NS / CLK_PERIOD_NS;
  localparam int DAC_COUNT = 6;
  localparam int PAGE_BYTES = 32;
  localparam int CFG_PAGES = 7;
  localparam int CFG_BYTES = PAGE_BYTES * CFG_PAGES;
  localparam int NVM_BYTES = 1024;
  localparam int SE_STATES = 63;
  localparam int SE_WORD_BYTES = 8;
  localparam logic [9:0] SE_NVM_BASE = 10'h200;
  localparam logic [15:0] NVM_BASE_ADDR = 16'hF800;
  localparam logic [7:0] REG_USER_RELOAD = 8'hD8;
  localparam logic [7:0] REG_UPDATE_CTRL = 8'hD9;
  localparam logic [7:0] REG_NVM_ADDR_HI = 8'hE0;
  localparam logic [7:0] REG_NVM_ADDR_LO = 8'hE1;
  localparam logic [7:0] REG_NVM_DATA = 8'hE2;
  localparam logic [7:0] REG_NVM_ERASE = 8'hE3;
  localparam logic [7:0] DAC_CODE_BASE = 8'h50;
  localparam logic [7:0] DAC_UPPER_BASE = 8'h60;
  localparam logic [7:0] DAC_LOWER_BASE = 8'h70;
  localparam int UPD_TRANSPARENT = 0;
  localparam int UPD_COMMIT = 1;
  localparam int UPD_ERASE_EN = 2;
  localparam int RELOAD_GO = 0;
  localparam logic [7:0] UPD_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {ST_LOCKOUT, ST_COPY, ST_XFER, ST_WAIT_SE, ST_READY} load_state_t;
endpackage : cfg_loader_pkg

/* File: dac_limit_clip.sv */
// Purpose: Clips one margining DAC code between its lower and upper limits.
// Assumes: Limits and code come from second-stage configuration latches.
// Notes: Outputs are registered.
`timescale 1ns/1ps
module dac_limit_clip (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cfg_valid,
  input wire logic [7:0] margin_dac_code,
  input wire logic [7:0] dac_lower_limit,
  input wire logic [7:0] dac_upper_limit,
  output logic [7:0] drive_code,
  output logic buffer_en
);
  logic below;
  logic above;
  logic inverted;
  logic [7:0] clipped;
  assign below = margin_dac_code < dac_lower_limit;
  assign above = margin_dac_code > dac_upper_limit;
  assign inverted = dac_lower_limit > dac_upper_limit;
  assign clipped = below ? dac_lower_limit : (above ? dac_upper_limit : margin_dac_code);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_code <= cfg_loader_pkg::ZERO_BYTE;
      buffer_en <= 1'b0;
    end
    else
    begin
      drive_code <= clipped;
      buffer_en <= cfg_valid && !inverted;
    end
  end
endmodule : dac_limit_clip

/* File: cfg_loader_properties.sv */
// Purpose: Port-level temporal checks for the configuration loader.
// Assumes: One clock domain with rstn as its asynchronous active-low reset.
// Notes: Bound into every cfg_loader instance.
`timescale 1ns/1ps
module cfg_loader_checker #(
  parameter int SE_START_CYCLES = 20,
  parameter int DAC_COUNT = 6
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic supply_above_lockout,
  input wire logic se_exit_met,
  input wire logic [5:0] se_state_index,
  input wire logic se_state_valid,
  input wire logic se_loading,
  input wire logic [DAC_COUNT-1:0] dac_buffer_en,
  input wire logic driver_weak_pull_en,
  input wire logic host_ack
);
  localparam int SE_LO = SE_START_CYCLES - 2;
  localparam int SE_HI = SE_START_CYCLES + 4;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_nack_dl;
    driver_weak_pull_en |-> !host_ack;
  endproperty
  a_nack_dl: assert property (p_nack_dl) else $error("ack before download end");
  property p_nack_lock;
    !supply_above_lockout |-> !host_ack;
  endproperty
  a_nack_lock: assert property (p_nack_lock) else $error("ack while locked out");
  property p_dl_time;
    $rose(supply_above_lockout) |-> ##[224:232] $fell(driver_weak_pull_en);
  endproperty
  a_dl_time: assert property (p_dl_time) else $error("download length wrong");
  property p_se_start;
    $fell(driver_weak_pull_en) |-> ##[SE_LO:SE_HI] $rose(se_loading);
  endproperty
  a_se_start: assert property (p_se_start) else $error("first state fetch late");
  property p_load_len;
    $rose(se_loading) |-> ##[500:500] ($fell(se_loading) && se_state_valid);
  endproperty
  a_load_len: assert property (p_load_len) else $error("state load length wrong");
  property p_exit_fetch;
    se_exit_met && se_state_valid && !se_loading |=> se_loading && !se_state_valid;
  endproperty
  a_exit_fetch: assert property (p_exit_fetch) else $error("exit did not fetch");
  property p_idx_step;
    $rose(se_loading) && $past(se_state_valid) |-> se_state_index ==
      (($past(se_state_index) == 6'h3E) ? 6'h00 : $past(se_state_index) + 6'h01);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("state index step wrong");
  property p_buf_off;
    driver_weak_pull_en |-> dac_buffer_en == '0;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer on before config");
endmodule : cfg_loader_checker
bind cfg_loader cfg_loader_checker #(
  .SE_START_CYCLES(SE_START_CYCLES),
  .DAC_COUNT(DAC_COUNT)
) u_chk (
  .clock(clock),
  .rstn(rstn),
  .supply_above_lockout(supply_above_lockout),
  .se_exit_met(se_exit_met),
  .se_state_index(se_state_index),
  .se_state_valid(se_state_valid),
  .se_loading(se_loading),
  .dac_buffer_en(dac_buffer_en),
  .driver_weak_pull_en(driver_weak_pull_en),
  .host_ack(host_ack)
);

/* File: host_model.sv */
// Purpose: Byte-level bus host that writes and reads loader registers.
// Assumes: Signals change on the falling clock edge.
// Notes: The byte lines show the inverted last byte when idle.
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic [7:0] host_rd_byte,
  output logic host_xfer_start,
  output logic host_wr_valid,
  output logic [7:0] host_wr_byte,
  output logic host_rd_req
);
  initial
  begin
    host_xfer_start = 1'b0;
    host_wr_valid = 1'b0;
    host_wr_byte = 8'h00;
    host_rd_req = 1'b0;
  end
  // Opens a transfer and sends the register pointer first.
  task automatic start(input logic [7:0] ptr);
    @(negedge clock);
    host_xfer_start = 1'b1;
    @(negedge clock);
    host_xfer_start = 1'b0;
    host_wr_valid = 1'b1;
    host_wr_byte = ptr;
  endtask : start
  // Writes one byte; also used for commit, reload and nonvolatile data writes.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    start(ptr);
    @(negedge clock);
    host_wr_byte = val;
    @(negedge clock);
    host_wr_valid = 1'b0;
    host_wr_byte = ~val;
  endtask : wr
  task automatic rd(input logic [7:0] ptr, output logic [7:0] val);
    start(ptr);
    @(negedge clock);
    host_wr_valid = 1'b0;
    host_wr_byte = ~ptr;
    host_rd_req = 1'b1;
    @(negedge clock);
    host_rd_req = 1'b0;
    @(negedge clock);
    val = host_rd_byte;
  endtask : rd
endmodule : host_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the configuration loader.
// Assumes: Nonvolatile contents are preloaded through the hierarchy.
// Notes: The first state fetch delay is shortened to 20 cycles.
`timescale 1ns/1ps
module tb_top;
  logic clock;
  logic rstn;
  logic supply_above_lockout;
  logic se_exit_met;
  logic host_xfer_start;
  logic host_wr_valid;
  logic [7:0] host_wr_byte;
  logic host_rd_req;
  logic [7:0] host_rd_byte;
  logic host_ack;
  logic [63:0] se_state_word;
  logic [5:0] se_state_index;
  logic se_state_valid;
  logic se_loading;
  logic [47:0] dac_drive_code;
  logic [5:0] dac_buffer_en;
  logic driver_weak_pull_en;
  logic config_ready;
  int bad_count;
  int n_checks;
  cfg_loader #(.SE_START_CYCLES(20)) u_dut (.clock(clock), .rstn(rstn),
    .supply_above_lockout(supply_above_lockout), .host_xfer_start(host_xfer_start),
    .host_wr_valid(host_wr_valid), .host_wr_byte(host_wr_byte), .host_rd_req(host_rd_req),
    .host_rd_byte(host_rd_byte), .host_ack(host_ack), .se_exit_met(se_exit_met),
    .se_state_word(se_state_word), .se_state_index(se_state_index),
    .se_state_valid(se_state_valid), .se_loading(se_loading),
    .dac_drive_code(dac_drive_code), .dac_buffer_en(dac_buffer_en),
    .driver_weak_pull_en(driver_weak_pull_en), .config_ready(config_ready));
  host_model u_host (.clock(clock), .host_rd_byte(host_rd_byte),
    .host_xfer_start(host_xfer_start), .host_wr_valid(host_wr_valid),
    .host_wr_byte(host_wr_byte), .host_rd_req(host_rd_req));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic chk_ch(input int k, input logic [7:0] code, input logic en);
    chk("drive_code", dac_drive_code[8*k+:8], code);
    chk("buffer_en", dac_buffer_en[k], en);
  endtask : chk_ch
  task automatic settle;
    repeat (4) @(negedge clock);
  endtask : settle
  task automatic wait_ready;
    int n;
    n = 0;
    while (config_ready !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
    end
    chk("config_ready", config_ready, 1'b1);
  endtask : wait_ready
  task automatic wait_se(input int idx);
    int n;
    logic [63:0] w;
    n = 0;
    for (int k = 0; k < 8; k++) w[8*k+:8] = 8'(8 * idx + k);
    while ((se_state_valid !== 1'b1 || se_loading !== 1'b0) && n < 1500)
    begin
      @(negedge clock);
      n++;
    end
    chk("se_index", se_state_index, 6'(idx));
    chk("se_word", se_state_word, w);
  endtask : wait_se
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    conclude();
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] codes [5];
    logic [7:0] exps [5];
    codes = '{8'hF0, 8'h30, 8'h40, 8'hC0, 8'h55};
    exps = '{8'hC0, 8'h40, 8'h40, 8'hC0, 8'h55};
    rstn = 1'b0;
    supply_above_lockout = 1'b0;
    se_exit_met = 1'b0;
    bad_count = 0;
    n_checks = 0;
    for (int i = 0; i < 1024; i++) u_dut.nvm_mem[i] = (i < 512) ? 8'h00 : 8'(i);
    for (int k = 0; k < 6; k++)
    begin
      u_dut.nvm_mem[8'h50 + k] = 8'h80;
      u_dut.nvm_mem[8'h60 + k] = 8'hC0;
      u_dut.nvm_mem[8'h70 + k] = 8'h40;
    end
    u_dut.nvm_mem[8'h75] = 8'hD0;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    u_host.rd(8'h60, v);
    chk("early_read", v, 8'h00);
    chk("early_ack", host_ack, 1'b0);
    chk("weak_pull", driver_weak_pull_en, 1'b1);
    supply_above_lockout = 1'b1;
    wait_ready();
    chk("weak_pull", driver_weak_pull_en, 1'b0);
    for (int k = 0; k < 5; k++) chk_ch(k, 8'h80, 1'b1);
    chk_ch(5, 8'hD0, 1'b0);
    u_host.wr(8'hD9, 8'h00);
    u_host.wr(8'h50, 8'h20);
    settle();
    chk_ch(0, 8'h80, 1'b1);
    u_host.rd(8'h50, v);
    chk("latch_a", v, 8'h20);
    u_host.wr(8'hD9, 8'h02);
    settle();
    chk_ch(0, 8'h40, 1'b1);
    u_host.rd(8'hD9, v);
    chk("update_ctrl", v, 8'h00);
    u_host.wr(8'hD9, 8'h01);
    for (int t = 0; t < 5; t++)
    begin
      u_host.wr(8'h51, codes[t]);
      settle();
      chk_ch(1, exps[t], 1'b1);
    end
    u_host.wr(8'h71, 8'hC1);
    settle();
    chk_ch(1, 8'hC1, 1'b0);
    u_host.wr(8'hD8, 8'h01);
    @(negedge clock);
    wait_ready();
    settle();
    chk_ch(0, 8'h80, 1'b1);
    chk_ch(1, 8'h80, 1'b1);
    wait_se(0);
    se_exit_met = 1'b1;
    @(negedge clock);
    se_exit_met = 1'b0;
    wait_se(1);
    u_host.wr(8'hE0, 8'hF8);
    u_host.wr(8'hE1, 8'h50);
    u_host.wr(8'hD9, 8'h00);
    u_host.wr(8'hE3, 8'h00);
    settle();
    chk("nvm_kept", u_dut.nvm_mem[10'h050], 8'h80);
    u_host.wr(8'hD9, 8'h04);
    u_host.wr(8'hE3, 8'h00);
    settle();
    chk("nvm_erased", u_dut.nvm_mem[10'h05F], 8'hFF);
    u_host.wr(8'hD9, 8'h00);
    u_host.wr(8'hE2, 8'h12);
    settle();
    chk("nvm_staged", u_dut.nvm_mem[10'h050], 8'hFF);
    u_host.wr(8'hD9, 8'h02);
    settle();
    chk("nvm_commit", u_dut.nvm_mem[10'h050], 8'h12);
    u_host.rd(8'hE2, v);
    chk("nvm_read", v, 8'h12);
    u_host.wr(8'hD9, 8'h01);
    u_host.wr(8'hE2, 8'h34);
    settle();
    chk("nvm_direct", u_dut.nvm_mem[10'h050], 8'h34);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    chk("reset_ack", host_ack, 1'b0);
    rstn = 1'b1;
    wait_ready();
    chk_ch(0, 8'h40, 1'b1);
    chk_ch(1, 8'hC0, 1'b1);
    conclude();
  end
endmodule : tb_top
